// ---- common/ivau_pkg.sv ----
// Constants and types for the interrupt vector address unit
package ivau_pkg;
  localparam int ADDR_W = 20;
  localparam int VEC_W = 20;
  localparam int NUM_W = 6;
  // Fixed table entries
  localparam logic [15:0] FIX_UNDEF    = 16'hFFDC;
  localparam logic [15:0] FIX_OVF      = 16'hFFE0;
  localparam logic [15:0] FIX_BRK      = 16'hFFE4;
  localparam logic [15:0] FIX_BRK_MARK = 16'hFFE6;
  localparam logic [15:0] FIX_ADDR_MAT = 16'hFFE8;
  localparam logic [15:0] FIX_STEP     = 16'hFFEC;
  localparam logic [15:0] FIX_NMI      = 16'hFFF0;
  localparam logic [15:0] FIX_ABRK     = 16'hFFF4;
  localparam logic [15:0] FIX_RESET    = 16'hFFFC;
  localparam logic [7:0]  BRK_RELOC_MARK = 8'hFF;
  localparam int ENTRY_BYTES = 4;
  localparam int RELOC_BYTES = 256;
  // Software interrupt numbers
  localparam logic [5:0] SW_BRK     = 6'h00;
  localparam logic [5:0] SW_FLASH   = 6'h01;
  localparam logic [5:0] SW_EXT4    = 6'h06;
  localparam logic [5:0] SW_SER2_TX = 6'h0B;
  localparam logic [5:0] SW_KEY     = 6'h0D;
  localparam logic [5:0] SW_CONV    = 6'h0E;
  localparam logic [5:0] SW_SYNC    = 6'h0F;
  localparam logic [5:0] SW_EXT2    = 6'h15;
  localparam logic [5:0] SW_SOFT_LO = 6'h20;
  localparam logic [5:0] SW_SOFT_HI = 6'h29;
  // Vector sources
  typedef enum logic [3:0] {
    IVAU_SRC_RESET, IVAU_SRC_UNDEF, IVAU_SRC_OVF, IVAU_SRC_BRK,
    IVAU_SRC_ADDR_MATCH, IVAU_SRC_STEP, IVAU_SRC_NMI, IVAU_SRC_ABRK,
    IVAU_SRC_MASKABLE, IVAU_SRC_SOFT
  } ivau_src_e;
endpackage : ivau_pkg

// ---- common/ivau_fetch_if.sv ----
// Byte fetch channel between the vector unit and its fetch engine
`timescale 1ns/1ps
`default_nettype none
interface ivau_fetch_if;
  logic        start;
  logic [15:0] base;
  logic        busy;
  logic        done;
  logic [31:0] word;
  logic        mem_req;
  logic [19:0] mem_addr;
  logic        mem_ack;
  logic [7:0]  mem_data;
  modport ctl (output start, output base, input busy, input done,
               input word);
  modport eng (input start, input base, output busy, output done,
               output word, output mem_req, output mem_addr,
               input mem_ack, input mem_data);
endinterface : ivau_fetch_if
`default_nettype wire

// ---- core/ivau_fetch.sv ----
// Four-byte vector fetch engine
`timescale 1ns/1ps
`default_nettype none
module ivau_fetch (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic [19:0] start_addr,
  ivau_fetch_if.eng        f
);
  import ivau_pkg::*;
  logic [19:0] addr;
  logic [1:0]  cnt;
  logic        busy;
  logic [31:0] word;
  logic        done;
  logic [19:0] next_addr;
  logic [1:0]  next_cnt;
  logic        next_busy;
  logic [31:0] next_word;
  logic        next_done;

  // Bytes come low first; a new start is ignored while busy
  always_comb begin
    next_addr = addr;
    next_cnt  = cnt;
    next_busy = busy;
    next_word = word;
    next_done = 1'b0;
    if (!busy && f.start) begin
      next_addr = start_addr;
      next_cnt  = 2'h0;
      next_busy = 1'b1;
    end else if (busy && f.mem_ack) begin
      next_word = {f.mem_data, word[31:8]};
      next_addr = addr + 20'h00001;
      next_cnt  = cnt + 2'h1;
      if (cnt == 2'h3) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr <= 20'h00000;
      cnt  <= 2'h0;
      busy <= 1'b0;
      word <= 32'h00000000;
      done <= 1'b0;
    end else begin
      addr <= next_addr;
      cnt  <= next_cnt;
      busy <= next_busy;
      word <= next_word;
      done <= next_done;
    end
  end

  assign f.mem_req  = busy;
  assign f.mem_addr = addr;
  assign f.busy     = busy;
  assign f.done     = done;
  assign f.word     = word;
endmodule : ivau_fetch
`default_nettype wire

// ---- core/ivau_top.sv ----
// Interrupt vector address unit: maps sources to vectors and fetches them
// Contract
// - Fixed table from FFDC up to reset FFFC
// - Every entry four bytes, four apart
// - Undefined-opcode trap uses FFDC
// - Overflow trap uses FFE0
// - Break reads FFE6; FF selects relocatable table
// - Monitor one, select zero, shares FFF0
// - Monitor two, select zero, shares FFF0
// - Relocatable table 256 bytes at base
// - Flash ready is number 1
// - External input four is number 6
// - Serial2 transmit is number 11
// - Key input is number 13
// - Converter done is number 14
// - Sync serial and I2C share 15
// - External input two is number 21
// - Break and software numbers ignore enable flag
// - Choice bit picks number 15 owner
// - Software numbers 32 to 41 at +128
`timescale 1ns/1ps
`default_nettype none
module ivau_top (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 req,
  input  wire ivau_pkg::ivau_src_e  src,
  input  wire logic [5:0]           irq_number,
  input  wire logic                 global_irq_enable,
  input  wire logic [19:0]          vector_base_register,
  input  wire logic                 monitor_one_nmi_select,
  input  wire logic                 monitor_two_nmi_select,
  input  wire logic                 monitor_one_irq,
  input  wire logic                 monitor_two_irq,
  input  wire logic                 serial_unit_choice_bit,
  output logic                      mem_req,
  output logic [19:0]               mem_addr,
  input  wire logic                 mem_ack,
  input  wire logic [7:0]           mem_data,
  output logic                      busy,
  output logic                      vec_valid,
  output logic [19:0]               vec_entry_addr,
  output logic [19:0]               handler_addr,
  output logic                      sync_from_i2c,
  output logic                      req_refused
);
  import ivau_pkg::*;

  // Boot fetches the reset entry; mark reads the break entry for its marker
  typedef enum logic [2:0] {
    IVAU_BOOT, IVAU_IDLE, IVAU_MARK, IVAU_FETCH, IVAU_DONE
  } ivau_state_e;

  // Sequencer state and the values it hands to the outputs
  ivau_state_e state;
  ivau_state_e next_state;
  logic [19:0] entry;
  logic [19:0] next_entry;
  logic [19:0] handler;
  logic [19:0] next_handler;
  logic        refused;
  logic        next_refused;
  logic        go;
  logic [19:0] go_addr;
  logic [19:0] fix_addr;
  logic [19:0] reloc_addr;
  logic [19:0] brk_reloc;
  logic        use_reloc;
  logic        allowed;
  logic        i2c_sel;
  logic        next_i2c_sel;
  logic [7:0]  mark_byte;

  // Marker byte position inside the little endian break entry
  localparam int MARK_LSB = 8 * int'(FIX_BRK_MARK - FIX_BRK);

  // One engine serves every fetch; it ignores a start while busy
  ivau_fetch_if f ();

  ivau_fetch u_fetch (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .start_addr (go_addr),
    .f          (f)
  );

  // Relocatable entry: base plus number times entry size
  assign reloc_addr = vector_base_register
                    + {12'h000, irq_number, 2'h0};
  assign brk_reloc  = vector_base_register
                    + {12'h000, SW_BRK, 2'h0};

  // Fixed table decode; reserved tool entries are kept reachable
  always_comb begin
    fix_addr  = {4'h0, FIX_RESET};
    use_reloc = 1'b0;
    allowed   = 1'b1;
    unique case (src)
      IVAU_SRC_RESET:      fix_addr = {4'h0, FIX_RESET};
      IVAU_SRC_UNDEF:      fix_addr = {4'h0, FIX_UNDEF};
      IVAU_SRC_OVF:        fix_addr = {4'h0, FIX_OVF};
      IVAU_SRC_BRK:        fix_addr = {4'h0, FIX_BRK};
      IVAU_SRC_ADDR_MATCH: fix_addr = {4'h0, FIX_ADDR_MAT};
      IVAU_SRC_STEP:       fix_addr = {4'h0, FIX_STEP};
      IVAU_SRC_NMI:        fix_addr = {4'h0, FIX_NMI};
      IVAU_SRC_ABRK:       fix_addr = {4'h0, FIX_ABRK};
      IVAU_SRC_SOFT:       use_reloc = 1'b1;
      IVAU_SRC_MASKABLE: begin
        // Monitors with select zero go non-maskable to the shared entry
        if ((monitor_one_irq && !monitor_one_nmi_select) ||
            (monitor_two_irq && !monitor_two_nmi_select)) begin
          fix_addr = {4'h0, FIX_NMI};
        end else begin
          use_reloc = 1'b1;
          allowed   = global_irq_enable;
        end
      end
      default: allowed = 1'b0;
    endcase
  end

  // Break needs the marker byte first, so it starts with a read of the whole fixed entry
  assign go = (state == IVAU_IDLE) && req && allowed;
  assign go_addr = (state == IVAU_BOOT) ? {4'h0, FIX_RESET} :
                   (state == IVAU_MARK) ? next_entry :
                   (src == IVAU_SRC_BRK) ? {4'h0, FIX_BRK} :
                   (use_reloc ? reloc_addr : fix_addr);
  // Base is not used by the engine; tied off
  assign f.base = 16'h0000;

  // Marker byte of the break entry, taken from the fetched word
  assign mark_byte = f.word[MARK_LSB +: 8];

  // Sequencer
  always_comb begin
    next_state   = state;
    next_entry   = entry;
    next_handler = handler;
    next_refused = 1'b0;
    f.start      = 1'b0;
    unique case (state)
      IVAU_BOOT: begin
        f.start    = 1'b1;
        next_entry = {4'h0, FIX_RESET};
        next_state = IVAU_FETCH;
      end
      IVAU_IDLE: begin
        if (req && !allowed) begin
          next_refused = 1'b1;
        end else if (go) begin
          f.start    = 1'b1;
          next_entry = go_addr;
          next_state = (src == IVAU_SRC_BRK) ? IVAU_MARK : IVAU_FETCH;
        end
      end
      IVAU_MARK: begin
        // Whole break entry read; the marker is its third byte
        next_entry = (mark_byte == BRK_RELOC_MARK)
                   ? brk_reloc : {4'h0, FIX_BRK};
        if (f.done) begin
          // Engine is idle again when done shows, so the restart is taken
          f.start    = (mark_byte == BRK_RELOC_MARK);
          next_state = f.start ? IVAU_FETCH : IVAU_DONE;
          next_handler = f.word[19:0];
        end
      end
      IVAU_FETCH: begin
        if (f.done) begin
          next_handler = f.word[19:0];
          next_state   = IVAU_DONE;
        end
      end
      IVAU_DONE: next_state = IVAU_IDLE;
      default:   next_state = IVAU_IDLE;
    endcase
  end

  // Reset lands in boot, so the reset entry is fetched first whatever
  // the base register holds
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state   <= IVAU_BOOT;
      entry   <= 20'h00000;
      handler <= 20'h00000;
      refused <= 1'b0;
    end else begin
      state   <= next_state;
      entry   <= next_entry;
      handler <= next_handler;
      refused <= next_refused;
    end
  end

  // Owner of number 15 is registered so the status is a clean data
  // output; it trails the choice bit by one cycle
  always_comb begin
    next_i2c_sel = serial_unit_choice_bit;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      i2c_sel <= 1'b0;
    end else begin
      i2c_sel <= next_i2c_sel;
    end
  end

  // Outputs; busy covers boot, so nothing is taken before the reset vector
  assign mem_req        = f.mem_req;
  assign mem_addr       = f.mem_addr;
  assign f.mem_ack      = mem_ack;
  assign f.mem_data     = mem_data;
  assign busy           = (state != IVAU_IDLE);
  assign vec_valid      = (state == IVAU_DONE);
  assign vec_entry_addr = entry;
  assign handler_addr   = handler;
  assign sync_from_i2c  = i2c_sel;
  assign req_refused    = refused;
endmodule : ivau_top
`default_nettype wire

// ---- dv/ivau_mem_model.sv ----
// Byte memory seen by the vector fetch, with optional stalls
`timescale 1ns/1ps
`default_nettype none
module ivau_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic [19:0] mem_addr,
  input  wire logic        stall,
  input  wire logic [7:0]  mark,
  output logic             mem_ack,
  output logic [7:0]       mem_data
);
  logic [7:0] last;
  // Answer at once unless stalled; idle bus shows inverse of last byte
  always_comb mem_ack = mem_req && !stall;
  always_comb begin
    mem_data = ~last;
    if (mem_ack) begin
      mem_data = (mem_addr == 20'h0FFE6) ? mark : mem_addr[7:0] ^ 8'h5A;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) last <= 8'h00;
    else if (mem_ack) last <= mem_data;
  end
endmodule : ivau_mem_model
`default_nettype wire

// ---- dv/ivau_top_assertions.sv ----
// Timing checks on the vector unit ports
`timescale 1ns/1ps
`default_nettype none
module ivau_top_assertions import ivau_pkg::*; (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        req,
  input wire ivau_src_e   src,
  input wire logic [5:0]  irq_number,
  input wire logic        global_irq_enable,
  input wire logic [19:0] vector_base_register,
  input wire logic        monitor_one_nmi_select,
  input wire logic        monitor_one_irq,
  input wire logic        monitor_two_irq,
  input wire logic        mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        busy,
  input wire logic        vec_valid,
  input wire logic        req_refused
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A request is only taken while idle
  logic go;
  assign go = req && !busy;
  property p_boot; $fell(rst) |-> ##[1:3] mem_req && mem_addr == 20'h0FFFC; endproperty
  a_boot: assert property (p_boot) else $error("boot fetch");
  property p_undef; go && src == IVAU_SRC_UNDEF |=> mem_addr == 20'h0FFDC; endproperty
  a_undef: assert property (p_undef) else $error("undef entry");
  property p_ovf; go && src == IVAU_SRC_OVF |=> mem_addr == 20'h0FFE0; endproperty
  a_ovf: assert property (p_ovf) else $error("ovf entry");
  property p_brk; go && src == IVAU_SRC_BRK |=> mem_addr == 20'h0FFE4; endproperty
  a_brk: assert property (p_brk) else $error("brk entry");
  property p_soft; go && src == IVAU_SRC_SOFT |=> mem_req &&
    mem_addr == $past(vector_base_register) + {$past(irq_number), 2'b00}; endproperty
  a_soft: assert property (p_soft) else $error("soft entry");
  property p_nmi; go && src == IVAU_SRC_MASKABLE && monitor_one_irq &&
    !monitor_one_nmi_select |=> mem_addr == 20'h0FFF0; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi entry");
  property p_refuse; go && src == IVAU_SRC_MASKABLE && !global_irq_enable &&
    !monitor_one_irq && !monitor_two_irq |=> req_refused && !mem_req; endproperty
  a_refuse: assert property (p_refuse) else $error("no refusal");
  property p_step; mem_ack && mem_addr[1:0] != 2'b11 |=>
    mem_req && mem_addr == $past(mem_addr) + 20'h1; endproperty
  a_step: assert property (p_step) else $error("byte step");
  property p_soft_free; go && src == IVAU_SRC_SOFT && !global_irq_enable
    |=> mem_req; endproperty
  a_soft_free: assert property (p_soft_free) else $error("soft held");
  property p_fixed_nmi; go && src == IVAU_SRC_NMI |=>
    mem_addr == 20'h0FFF0; endproperty
  a_fixed_nmi: assert property (p_fixed_nmi) else $error("nmi fixed");
  property p_amatch; go && src == IVAU_SRC_ADDR_MATCH |=>
    mem_addr == 20'h0FFE8; endproperty
  a_amatch: assert property (p_amatch) else $error("match entry");
  c_soft: cover property (go && src == IVAU_SRC_SOFT);
  c_refuse: cover property (req_refused);
  c_nmi: cover property (go && monitor_one_irq && !monitor_one_nmi_select);
endmodule : ivau_top_assertions
`default_nettype wire

// ---- dv/ivau_top_test.sv ----
// Directed bench for the interrupt vector address unit
`timescale 1ns/1ps
`default_nettype none
module ivau_top_test;
  import ivau_pkg::*;
  logic ref_clk, rst, req, global_irq_enable, monitor_one_nmi_select;
  logic monitor_two_nmi_select, monitor_one_irq, monitor_two_irq, busy;
  logic serial_unit_choice_bit, mem_req, mem_ack, vec_valid, slow, stall;
  logic sync_from_i2c, req_refused;
  logic [5:0] irq_number;
  logic [7:0] mem_data, mark;
  logic [19:0] vector_base_register, mem_addr, vec_entry_addr, handler_addr;
  ivau_src_e src;
  int n_fail, samples_checked, p, i;
  logic [5:0] nums [10] = '{6'h01, 6'h06, 6'h0B, 6'h0D, 6'h0E, 6'h0F,
                            6'h15, 6'h20, 6'h29, 6'h3F};
  ivau_top DUT (.ref_clk, .rst, .req, .src, .irq_number, .global_irq_enable,
    .vector_base_register, .monitor_one_nmi_select, .monitor_two_nmi_select,
    .monitor_one_irq, .monitor_two_irq, .serial_unit_choice_bit, .mem_req,
    .mem_addr, .mem_ack, .mem_data, .busy, .vec_valid, .vec_entry_addr,
    .handler_addr, .sync_from_i2c, .req_refused);
  ivau_mem_model u_mem (.ref_clk, .rst, .mem_req, .mem_addr, .stall, .mark,
    .mem_ack, .mem_data);
  always #10 ref_clk = ~ref_clk;
  // Slow mode stalls every other cycle
  always @(posedge ref_clk) stall <= slow & ~stall;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] bt(input logic [19:0] a);
    bt = (a == 20'h0FFE6) ? mark : a[7:0] ^ 8'h5A;
  endfunction : bt
  // Handler is the low 20 bits of the little endian entry
  function automatic logic [19:0] hx(input logic [19:0] e);
    logic [7:0] b2;
    b2 = bt(e + 20'h2);
    hx = {b2[3:0], bt(e + 20'h1), bt(e)};
  endfunction : hx
  task automatic wv(input logic [19:0] e);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (vec_valid !== 1'b1 && k < 99);
    chk({19'h0, vec_valid}, 20'h1);
    chk(vec_entry_addr, e);
    chk(handler_addr, hx(e));
    // Next stimulus then starts on a clock edge
    @(posedge ref_clk);
  endtask : wv
  task automatic run(input ivau_src_e s, input logic [5:0] n,
                     input logic [19:0] e);
    @(posedge ref_clk);
    src <= s;
    irq_number <= n;
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    wv(e);
  endtask : run
  task automatic end_sim;
    $display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    end_sim;
  end
  initial begin
    {ref_clk, req, global_irq_enable, monitor_one_irq, monitor_two_irq} = '0;
    {serial_unit_choice_bit, slow, irq_number, mark} = '0;
    {monitor_one_nmi_select, monitor_two_nmi_select, rst} = '1;
    src = IVAU_SRC_RESET;
    vector_base_register = 20'h0C400;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wv(20'h0FFFC);
    // Tool-only entries other than address match are never requested, as software must not use them
    for (p = 0; p < 2; p++) begin
      slow <= p[0];
      run(IVAU_SRC_UNDEF, 6'h00, 20'h0FFDC);
      run(IVAU_SRC_OVF, 6'h00, 20'h0FFE0);
      run(IVAU_SRC_BRK, 6'h00, 20'h0FFE4);
      run(IVAU_SRC_ADDR_MATCH, 6'h00, 20'h0FFE8);
      run(IVAU_SRC_NMI, 6'h00, 20'h0FFF0);
      run(IVAU_SRC_RESET, 6'h00, 20'h0FFFC);
      for (i = 0; i < 10; i++) begin
        run(IVAU_SRC_SOFT, nums[i], 20'h0C400 + {nums[i], 2'b00});
      end
    end
    mark <= 8'hFF;
    run(IVAU_SRC_BRK, 6'h00, 20'h0C400);
    global_irq_enable <= 1'b1;
    run(IVAU_SRC_MASKABLE, 6'h06, 20'h0C418);
    monitor_one_irq <= 1'b1;
    monitor_one_nmi_select <= 1'b0;
    run(IVAU_SRC_MASKABLE, 6'h0E, 20'h0FFF0);
    monitor_one_irq <= 1'b0;
    monitor_two_irq <= 1'b1;
    run(IVAU_SRC_MASKABLE, 6'h33, 20'h0C4CC);
    monitor_two_nmi_select <= 1'b0;
    run(IVAU_SRC_MASKABLE, 6'h33, 20'h0FFF0);
    {global_irq_enable, monitor_two_irq} <= 2'b00;
    run(IVAU_SRC_SOFT, 6'h0F, 20'h0C43C);
    @(posedge ref_clk);
    src <= IVAU_SRC_MASKABLE;
    req <= 1'b1;
    serial_unit_choice_bit <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    #1;
    chk({19'h0, req_refused}, 20'h1);
    chk({19'h0, sync_from_i2c}, 20'h1);
    end_sim;
  end
endmodule : ivau_top_test
bind ivau_top ivau_top_assertions u_chk (.ref_clk, .rst, .req, .src,
  .irq_number, .global_irq_enable, .vector_base_register,
  .monitor_one_nmi_select, .monitor_one_irq, .monitor_two_irq, .mem_req,
  .mem_addr, .mem_ack, .busy, .vec_valid, .req_refused);
`default_nettype wire
